// ---- logic/switch_ctrl_pkg.sv ----
package switch_ctrl_pkg;
	// register byte offsets (aligned words)
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_IRQ_ST = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MK = 12'h00C;
	localparam logic [11:0] ADDR_RETRY  = 12'h010;
	localparam logic [11:0] ADDR_STBY   = 12'h014;
	// control fields
	localparam int CTRL_VARIANT_C = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// interrupt event bit positions
	localparam int EV_SHUTDOWN = 0;
	localparam int EV_RETRY    = 1;
	localparam int EV_OFFDIAG  = 2;
	localparam int EV_REVERSE  = 3;
	localparam int EV_STANDBY  = 4;
	localparam int EV_W        = 5;
	localparam logic [EV_W-1:0] MASK_RESET = 5'h00;
	// timing
	localparam int CLK_MHZ        = 250;
	localparam int RETRY_US       = 1;
	localparam int STBY_US        = 1;
	localparam logic [31:0] RETRY_CYC = 32'(RETRY_US * CLK_MHZ);
	localparam logic [31:0] STBY_CYC  = 32'(STBY_US * CLK_MHZ);
	// sense mux selection
	typedef enum logic [1:0] {
		SENSE_HIGHZ = 2'h0,
		SENSE_CURR  = 2'h1,
		SENSE_TEMP  = 2'h3,
		SENSE_FAULT = 2'h2
	} sense_mode_e;
	// device states, gray along standby->delay->diag->active->fault
	typedef enum logic [2:0] {
		ST_STANDBY  = 3'h0,
		ST_DELAY    = 3'h1,
		ST_DIAG     = 3'h3,
		ST_ACTIVE   = 3'h2,
		ST_FAULT    = 3'h6
	} dev_state_e;
endpackage

// ---- logic/switch_fault_diag_control.sv ----
// Functional notes
// - during load dump the switch keeps its present on or off state unless reverse polarity forces it on
// - reverse polarity forces switch on regardless of enable if select grounded
// - latched shutdown holds switch off while retry-hold stays high, unless reverse polarity forces it on
// - retry-hold low: re-enable after fault clears and retry timer expires
// - active-regulation variant shuts off only on thermal trip
// - on retry hold fault level until output rises near supply
// - output never rising keeps fault indication without time bound
// - off with diagnostics on: flag fault when output above open-load level
// - off-state detection only while diagnostic enable high and enable low
// - fault shown only with sense select low, else temperature while diagnostic enable high
// - off-state indication tracks live comparator, no latching
// - off-state indication cleared on diag-enable fall and enable rise
// - no fault, diagnostic enable high: select low reports current, high reports temperature; diagnostic enable low gives high-Z
// - fault with fault reporting selected drives fixed fault level
// - release hold-off only when hold low, timer done, faults cleared
// - open-load and short-to-battery suppressed while switch on
// - both enables low enters delay; standby if still low at expiry
`timescale 1ns/100ps
module switch_fault_diag_control (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// host control pins
	input  wire logic        enable,
	input  wire logic        diagnostic_enable,
	input  wire logic        retry_hold,
	input  wire logic        sense_select,
	// comparator results
	input  wire logic        open_load_cmp,
	input  wire logic        output_risen,
	input  wire logic        thermal_trip,
	input  wire logic        current_limit_trip,
	input  wire logic        reverse_polarity,
	input  wire logic        load_dump,
	// power stage and sense mux
	output logic             switch_on,
	output logic      [1:0]  sense_mode,
	output logic             sense_fault,
	output logic             standby,
	output logic             irq
);
	switch_ctrl_pkg::dev_state_e state_r, state_nxt;
	logic [31:0]  ctrl_r, ctrl_nxt;
	logic [31:0]  retry_len_r, retry_len_nxt;
	logic [31:0]  stby_len_r, stby_len_nxt;
	logic [31:0]  cnt_r, cnt_nxt;
	logic [switch_ctrl_pkg::EV_W-1:0] ist_r, ist_nxt, imk_r, imk_nxt;
	logic         sw_r, sw_nxt;
	logic         retry_pend_r, retry_pend_nxt;
	logic         offd_r, offd_nxt;
	logic         en_d_r, dia_d_r;
	logic [1:0]   mode_r, mode_nxt;
	logic         fault_r, fault_nxt;
	logic [31:0]  rdata_r, rdata_nxt;
	logic [switch_ctrl_pkg::EV_W-1:0] ev;
	logic         offd_rise;
	logic         wr, rd, trip, off_diag_on, en_rise, dia_fall, fault_det;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		return a == o;
	endfunction

	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;
	// variant C keeps regulating through current limit
	assign trip = thermal_trip ||
		(current_limit_trip && !ctrl_r[switch_ctrl_pkg::CTRL_VARIANT_C]);
	assign off_diag_on = diagnostic_enable && !enable && !sw_r;
	assign en_rise  = enable && !en_d_r;
	assign dia_fall = !diagnostic_enable && dia_d_r;

	always_comb begin
		state_nxt = state_r;
		sw_nxt = sw_r;
		cnt_nxt = cnt_r;
		retry_pend_nxt = retry_pend_r;
		ev = '0;
		unique case (state_r)
		switch_ctrl_pkg::ST_STANDBY: begin
			sw_nxt = 1'b0;
			if (enable) begin
				state_nxt = switch_ctrl_pkg::ST_ACTIVE;
				sw_nxt = 1'b1;
			end else if (diagnostic_enable) begin
				state_nxt = switch_ctrl_pkg::ST_DIAG;
			end
		end
		switch_ctrl_pkg::ST_DELAY: begin
			sw_nxt = 1'b0;
			if (enable) begin
				state_nxt = switch_ctrl_pkg::ST_ACTIVE;
				sw_nxt = 1'b1;
			end else if (diagnostic_enable) begin
				state_nxt = switch_ctrl_pkg::ST_DIAG;
			end else if (cnt_r + 32'h1 >= stby_len_r) begin
				state_nxt = switch_ctrl_pkg::ST_STANDBY;
				ev[switch_ctrl_pkg::EV_STANDBY] = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 32'h1;
			end
		end
		switch_ctrl_pkg::ST_DIAG: begin
			sw_nxt = 1'b0;
			if (enable) begin
				state_nxt = switch_ctrl_pkg::ST_ACTIVE;
				sw_nxt = 1'b1;
			end else if (!diagnostic_enable) begin
				state_nxt = switch_ctrl_pkg::ST_DELAY;
				cnt_nxt = '0;
			end
		end
		switch_ctrl_pkg::ST_ACTIVE: begin
			if (trip) begin
				state_nxt = switch_ctrl_pkg::ST_FAULT;
				sw_nxt = 1'b0;
				cnt_nxt = '0;
				ev[switch_ctrl_pkg::EV_SHUTDOWN] = 1'b1;
			end else if (!enable) begin
				sw_nxt = 1'b0;
				retry_pend_nxt = 1'b0;
				state_nxt = diagnostic_enable ? switch_ctrl_pkg::ST_DIAG
					: switch_ctrl_pkg::ST_DELAY;
				cnt_nxt = '0;
			end else begin
				sw_nxt = 1'b1;
				// fault level held until output climbs, forever if shorted
				if (output_risen)
					retry_pend_nxt = 1'b0;
			end
		end
		switch_ctrl_pkg::ST_FAULT: begin
			sw_nxt = 1'b0;
			if (cnt_r < retry_len_r)
				cnt_nxt = cnt_r + 32'h1;
			if (!retry_hold && cnt_r >= retry_len_r && !thermal_trip &&
				!current_limit_trip) begin
				ev[switch_ctrl_pkg::EV_RETRY] = 1'b1;
				cnt_nxt = '0;
				if (enable) begin
					state_nxt = switch_ctrl_pkg::ST_ACTIVE;
					sw_nxt = 1'b1;
					retry_pend_nxt = 1'b1;
				end else begin
					state_nxt = diagnostic_enable ? switch_ctrl_pkg::ST_DIAG
						: switch_ctrl_pkg::ST_DELAY;
				end
			end
		end
		default: begin
			state_nxt = switch_ctrl_pkg::ST_STANDBY;
			sw_nxt = 1'b0;
		end
		endcase
		// transient on the supply leaves the switch where it was
		if (load_dump) begin
			state_nxt = state_r;
			sw_nxt = sw_r;
			cnt_nxt = cnt_r;
			retry_pend_nxt = retry_pend_r;
			ev = '0;
		end
		if (reverse_polarity && !sense_select) begin
			sw_nxt = 1'b1;
			ev[switch_ctrl_pkg::EV_REVERSE] = 1'b1;
		end
	end

	// off-state detection follows the comparator live
	always_comb begin
		offd_nxt = off_diag_on && open_load_cmp;
		if (en_rise || dia_fall)
			offd_nxt = 1'b0;
	end

	// kept apart from ev so that every event vector has one driver
	assign offd_rise = offd_nxt && !offd_r;

	assign fault_det = state_r == switch_ctrl_pkg::ST_FAULT || retry_pend_r ||
		(sw_r && current_limit_trip) || offd_r;

	always_comb begin
		fault_nxt = fault_det && !sense_select;
		if (!diagnostic_enable)
			mode_nxt = switch_ctrl_pkg::SENSE_HIGHZ;
		else if (sense_select)
			mode_nxt = switch_ctrl_pkg::SENSE_TEMP;
		else if (fault_det)
			mode_nxt = switch_ctrl_pkg::SENSE_FAULT;
		else
			mode_nxt = switch_ctrl_pkg::SENSE_CURR;
	end

	// register file; set wins over write-one-to-clear
	always_comb begin
		ctrl_nxt = ctrl_r;
		retry_len_nxt = retry_len_r;
		stby_len_nxt = stby_len_r;
		imk_nxt = imk_r;
		ist_nxt = ist_r;
		rdata_nxt = rdata_r;
		if (wr) begin
			if (hit(paddr, switch_ctrl_pkg::ADDR_CTRL))
				ctrl_nxt = {31'h0, pwdata[switch_ctrl_pkg::CTRL_VARIANT_C]};
			if (hit(paddr, switch_ctrl_pkg::ADDR_IRQ_ST))
				ist_nxt = ist_r & ~pwdata[switch_ctrl_pkg::EV_W-1:0];
			if (hit(paddr, switch_ctrl_pkg::ADDR_IRQ_MK))
				imk_nxt = pwdata[switch_ctrl_pkg::EV_W-1:0];
			if (hit(paddr, switch_ctrl_pkg::ADDR_RETRY))
				retry_len_nxt = pwdata;
			if (hit(paddr, switch_ctrl_pkg::ADDR_STBY))
				stby_len_nxt = pwdata;
		end
		ist_nxt = ist_nxt | ev;
		if (offd_rise)
			ist_nxt[switch_ctrl_pkg::EV_OFFDIAG] = 1'b1;
		if (rd && !penable) begin
			unique case (paddr)
			switch_ctrl_pkg::ADDR_CTRL:   rdata_nxt = ctrl_r;
			switch_ctrl_pkg::ADDR_STATUS: rdata_nxt = {24'h0, fault_r,
				offd_r, retry_pend_r, sw_r, 1'b0, 3'(state_r)};
			switch_ctrl_pkg::ADDR_IRQ_ST: rdata_nxt = {27'h0, ist_r};
			switch_ctrl_pkg::ADDR_IRQ_MK: rdata_nxt = {27'h0, imk_r};
			switch_ctrl_pkg::ADDR_RETRY:  rdata_nxt = retry_len_r;
			switch_ctrl_pkg::ADDR_STBY:   rdata_nxt = stby_len_r;
			default:                      rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= switch_ctrl_pkg::ST_STANDBY;
			sw_r <= 1'b0;
			cnt_r <= '0;
			retry_pend_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sw_r <= sw_nxt;
			cnt_r <= cnt_nxt;
			retry_pend_r <= retry_pend_nxt;
		end
	end

	// edge history resets to idle pin level: no false edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offd_r <= 1'b0;
			en_d_r <= 1'b0;
			dia_d_r <= 1'b0;
		end else begin
			offd_r <= offd_nxt;
			en_d_r <= enable;
			dia_d_r <= diagnostic_enable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= switch_ctrl_pkg::SENSE_HIGHZ;
			fault_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			fault_r <= fault_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= switch_ctrl_pkg::CTRL_RESET;
			retry_len_r <= switch_ctrl_pkg::RETRY_CYC;
			stby_len_r <= switch_ctrl_pkg::STBY_CYC;
			ist_r <= '0;
			imk_r <= switch_ctrl_pkg::MASK_RESET;
			rdata_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			retry_len_r <= retry_len_nxt;
			stby_len_r <= stby_len_nxt;
			ist_r <= ist_nxt;
			imk_r <= imk_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign prdata = rdata_r;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign switch_on = sw_r;
	assign sense_mode = mode_r;
	assign sense_fault = fault_r;
	assign standby = state_r == switch_ctrl_pkg::ST_STANDBY;
	assign irq = |(ist_r & imk_r);
endmodule

// ---- bench/host_model.sv ----
`timescale 1ns/100ps
module host_model (
	// clock and host command {enable, diag enable, select, hold}
	input  wire logic       pclk,
	input  wire logic [3:0] cmd,
	// control pins
	output logic            enable,
	output logic            diagnostic_enable,
	output logic            sense_select,
	output logic            retry_hold,
	// sense sampling
	input  wire logic       sense_fault,
	output logic            fault_seen
);
	initial {enable, diagnostic_enable, sense_select, retry_hold} = 4'h0;
	// pins move only after an edge, like a port register of the host
	always @(posedge pclk) begin
		{enable, diagnostic_enable, sense_select, retry_hold} <= cmd;
	end
	// fault level means a fault only while select is low
	assign fault_seen = sense_fault && !sense_select;
endmodule

// ---- bench/switch_fault_diag_control_chk.sv ----
`timescale 1ns/100ps
module switch_fault_diag_control_chk (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// pins and comparators
	input wire logic       enable,
	input wire logic       diagnostic_enable,
	input wire logic       retry_hold,
	input wire logic       sense_select,
	input wire logic       open_load_cmp,
	input wire logic       output_risen,
	input wire logic       thermal_trip,
	input wire logic       current_limit_trip,
	input wire logic       reverse_polarity,
	input wire logic       load_dump,
	// outputs
	input wire logic       switch_on,
	input wire logic [1:0] sense_mode,
	input wire logic       sense_fault,
	input wire logic       standby
);
	logic both_low;
	logic trip;
	assign both_low = !enable && !diagnostic_enable;
	assign trip = thermal_trip || current_limit_trip;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence latched_off;
		$fell(switch_on) && retry_hold && $past(trip) ##1
		(retry_hold && !reverse_polarity && !load_dump) [*8];
	endsequence
	chk_latch_holds: assert property (latched_off |-> !switch_on)
		else $error("switch left hold-off");
	chk_fault_level: assert property (sense_fault &&
		$past(diagnostic_enable) |->
		sense_mode == switch_ctrl_pkg::SENSE_FAULT)
		else $error("fault not at fault level");
	chk_fault_sel_low: assert property (sense_fault |->
		!$past(sense_select)) else $error("fault with select high");
	chk_temp_sel: assert property ($past(sense_select) &&
		$past(diagnostic_enable) && !$past(standby) && $past(presetn)
		|-> sense_mode == switch_ctrl_pkg::SENSE_TEMP)
		else $error("select high not temperature");
	chk_reverse_on: assert property (reverse_polarity && !sense_select &&
		!load_dump |=> switch_on) else $error("reverse not forced on");
	chk_dump_freeze: assert property (load_dump && !reverse_polarity
		|=> $stable(switch_on)) else $error("switch moved in dump");
	chk_open_flag: assert property (!switch_on && !enable &&
		diagnostic_enable && $past(diagnostic_enable) && !sense_select &&
		open_load_cmp && !reverse_polarity && !load_dump
		|-> ##[1:3] sense_fault) else $error("open load not flagged");
	chk_onstate_quiet: assert property (switch_on && enable &&
		open_load_cmp && !sense_select && !trip && !load_dump &&
		sense_mode == switch_ctrl_pkg::SENSE_CURR |=> !sense_fault)
		else $error("open load shown while on");
	chk_retry_fault: assert property (switch_on && enable &&
		diagnostic_enable && !sense_select && !output_risen && !trip &&
		sense_mode == switch_ctrl_pkg::SENSE_FAULT
		|=> sense_mode == switch_ctrl_pkg::SENSE_FAULT)
		else $error("retry fault dropped early");
	chk_standby_wait: assert property ($rose(standby) |->
		$past(both_low) && $past(both_low, 8)) else $error("early standby");
endmodule
bind switch_fault_diag_control switch_fault_diag_control_chk u_chk (
	.pclk, .presetn, .enable, .diagnostic_enable, .retry_hold,
	.sense_select, .open_load_cmp, .output_risen, .thermal_trip,
	.current_limit_trip, .reverse_polarity, .load_dump, .switch_on,
	.sense_mode, .sense_fault, .standby);

// ---- bench/switch_fault_diag_control_bench.sv ----
`timescale 1ns/100ps
module switch_fault_diag_control_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        enable, diagnostic_enable, retry_hold, sense_select;
	logic        open_load_cmp, output_risen, thermal_trip;
	logic        current_limit_trip, reverse_polarity, load_dump;
	logic        switch_on, sense_fault, standby, irq, seen;
	logic [1:0]  sense_mode;
	logic [3:0]  cmd;
	int          checks, fails;
	// {enable, diag enable, select, open load, switch, sense mode}
	logic [6:0]  rows [7] = '{7'h65, 7'h77, 7'h6D, 7'h2A, 7'h3B, 7'h21, 7'h44};

	switch_fault_diag_control u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enable,
		.diagnostic_enable, .retry_hold, .sense_select, .open_load_cmp,
		.output_risen, .thermal_trip, .current_limit_trip,
		.reverse_polarity, .load_dump, .switch_on, .sense_mode,
		.sense_fault, .standby, .irq);
	host_model u_host (.pclk, .cmd, .enable, .diagnostic_enable,
		.sense_select, .retry_hold, .sense_fault, .fault_seen(seen));

	task ck(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task results;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		#20us;
		fails++;
		results;
	end
	initial begin
		{presetn, psel, penable, pwrite, open_load_cmp, output_risen} = '0;
		{thermal_trip, current_limit_trip, reverse_polarity, load_dump} = '0;
		{paddr, pwdata, cmd} = '0;
		wt(12);
		presetn <= 1'b1;
		ck({standby, switch_on, irq}, 3'h4);
		// short retry and standby spans keep the run brief
		bus(1'b1, 12'h010, 32'h14);
		bus(1'b1, 12'h014, 32'h0A);
		bus(1'b1, 12'h00C, 32'h1F);
		bus(1'b0, 12'h010, 32'h0);
		ck(q, 32'h14);
		bus(1'b0, 12'h100, 32'h0);
		ck(q, 32'h0);
		ck({pready, pslverr}, 2'h2);
		for (int i = 0; i < 7; i++) begin
			cmd <= {rows[i][6:4], 1'b0};
			open_load_cmp <= rows[i][3];
			wt(8);
			ck({switch_on, sense_mode}, rows[i][2:0]);
		end
		cmd <= 4'hD;
		open_load_cmp <= 1'b0;
		wt(8);
		current_limit_trip <= 1'b1;
		wt(1);
		current_limit_trip <= 1'b0;
		wt(40);
		ck({switch_on, sense_mode, irq}, 4'h5);
		bus(1'b1, 12'h00C, 32'h0);
		wt(2);
		ck(irq, 1'b0);
		bus(1'b1, 12'h00C, 32'h1F);
		bus(1'b1, 12'h008, 32'h1F);
		wt(2);
		ck(irq, 1'b0);
		cmd <= 4'hC;
		for (int k = 0; k < 60 && switch_on !== 1'b1; k++) @(posedge pclk);
		ck(switch_on, 1'b1);
		wt(4);
		ck({sense_mode, irq}, 3'h5);
		output_risen <= 1'b1;
		wt(4);
		ck(sense_mode, 2'h1);
		// variant C rides through current limit, thermal still shuts off
		bus(1'b1, 12'h000, 32'h1);
		bus(1'b0, 12'h000, 32'h0);
		ck(q, 32'h1);
		current_limit_trip <= 1'b1;
		wt(4);
		ck({switch_on, sense_mode}, 3'h6);
		thermal_trip <= 1'b1;
		wt(4);
		ck(switch_on, 1'b0);
		{thermal_trip, current_limit_trip} <= 2'h0;
		for (int k = 0; k < 60 && switch_on !== 1'b1; k++) @(posedge pclk);
		ck(switch_on, 1'b1);
		load_dump <= 1'b1;
		cmd <= 4'h0;
		wt(5);
		ck(switch_on, 1'b1);
		load_dump <= 1'b0;
		cmd <= 4'h4;
		open_load_cmp <= 1'b1;
		wt(8);
		ck({switch_on, sense_fault, seen}, 3'h3);
		cmd <= 4'h0;
		wt(4);
		ck(sense_fault, 1'b0);
		reverse_polarity <= 1'b1;
		wt(4);
		ck(switch_on, 1'b1);
		{reverse_polarity, open_load_cmp} <= 2'h0;
		wt(30);
		ck(standby, 1'b1);
		results;
	end
endmodule
